// File: hw/vfic_consts.vh
`ifndef VFIC_CONSTS_VH
`define VFIC_CONSTS_VH
// ----------------------------------------
// Register indices (byte address is index times 4)
// ----------------------------------------
`define VFIC_IDX_FMT 8'h15
`define VFIC_IDX_TEST_A 8'h16
`define VFIC_IDX_TEST_B 8'h17
`define VFIC_IDX_TEST_C 8'h18
`define VFIC_IDX_TEST_D 8'h19
`define VFIC_IDX_GAIN_R 8'h01
`define VFIC_IDX_GAIN_G 8'h02
`define VFIC_IDX_GAIN_B 8'h03
`define VFIC_IDX_OFS_R 8'h04
`define VFIC_IDX_OFS_G 8'h05
`define VFIC_IDX_OFS_B 8'h06
`define VFIC_IDX_CLAMP 8'h07
`define VFIC_IDX_STATUS 8'h08
// ----------------------------------------
// Format register fields
// ----------------------------------------
`define VFIC_FMT_DUAL 7
`define VFIC_FMT_OUTMODE 6
`define VFIC_FMT_ODDSWAP 5
`define VFIC_FMT_422 4
`define VFIC_FMT_SRC 3
`define VFIC_FMT_BW_HI 2
`define VFIC_FMT_BW_LO 1
`define VFIC_FMT_EXTCLK 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define VFIC_RST_FMT 8'hC6
`define VFIC_RST_TEST_A 8'hFF
`define VFIC_RST_TEST_B 8'h00
`define VFIC_RST_GAIN 8'h80
`define VFIC_RST_OFS 7'h40
`define VFIC_RST_CLAMP 1'h0
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define VFIC_RESP_OKAY 2'h0
`define VFIC_RESP_SLVERR 2'h2
`endif

// File: hw/vfic_sync_upd.v
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Setting shadow, loaded on update strobe
// ----------------------------------------
module vfic_sync_upd #(
    parameter W = 8,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire upd_i,
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q_o <= INIT;
        else if (upd_i)
            q_o <= d_i;
    end
endmodule
`default_nettype wire

// File: hw/vfic_top.v
// Contract
// - Source select bit 0 picks video port 0, bit 1 picks port 1.
// - All video and sync signals of a port switch together.
// - Two-bit bandwidth code 11/10/01/00, reset value 11.
// - Clock source bit 0 uses internal PLL clock, 1 external.
// - Per-channel 8-bit gain code, reset 80h.
// - Per-channel 7-bit offset code, higher code lowers output.
// - Clamp all to zero scale; option clamps red and blue mid.
// - Three 8-bit converters, one sample per pixel clock each.
// - Each channel output on one port or two 8-bit ports.
// - 4:2:2 mode: red carries U/V, green luma, blue high Z.
`timescale 1ns/100ps
`default_nettype none
`include "vfic_consts.vh"
module vfic_top (
    input wire clk_i,
    input wire rst_n_i,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire pix_upd_i,
    input wire [7:0] port0_r_i,
    input wire [7:0] port0_g_i,
    input wire [7:0] port0_b_i,
    input wire port0_hs_i,
    input wire port0_vs_i,
    input wire [7:0] port1_r_i,
    input wire [7:0] port1_g_i,
    input wire [7:0] port1_b_i,
    input wire port1_hs_i,
    input wire port1_vs_i,
    input wire [7:0] test_c_i,
    input wire [7:0] test_d_i,
    output reg [7:0] r_a_o,
    output reg [7:0] r_b_o,
    output reg [7:0] g_a_o,
    output reg [7:0] g_b_o,
    output reg [7:0] b_a_o,
    output reg [7:0] b_b_o,
    output reg b_oe_n_o,
    output reg hs_o,
    output reg vs_o,
    output reg ext_clk_sel_o,
    output reg [1:0] bandwidth_o,
    output reg [23:0] gain_o,
    output reg [20:0] offset_o,
    output reg clamp_mid_rb_o,
    output reg src_sel_o
);
    // ----------------------------------------
    // Software-facing registers
    // ----------------------------------------
    reg [7:0] fmt_r;
    reg [7:0] test_a_r;
    reg [7:0] test_b_r;
    reg [7:0] gain_r_r;
    reg [7:0] gain_g_r;
    reg [7:0] gain_b_r;
    reg [6:0] ofs_r_r;
    reg [6:0] ofs_g_r;
    reg [6:0] ofs_b_r;
    reg clamp_r;
    reg [31:0] awaddr_r;
    reg aw_have_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    reg w_have_r;
    reg phase_r;
    reg uv_ph_r;
    wire [7:0] fmt_act;
    wire [7:0] gr_act;
    wire [7:0] gg_act;
    wire [7:0] gb_act;
    wire [6:0] or_act;
    wire [6:0] og_act;
    wire [6:0] ob_act;
    wire cl_act;
    wire [7:0] waddr;
    wire [7:0] wbyte;
    wire do_write;
    wire [7:0] raddr;
    assign waddr = aw_have_r ? awaddr_r[9:2] : s_axi_awaddr[9:2];
    assign wbyte = w_have_r ? wdata_r[7:0] : s_axi_wdata[7:0];
    assign do_write = (aw_have_r || s_axi_awvalid) &&
        (w_have_r || s_axi_wvalid) && !s_axi_bvalid &&
        (w_have_r ? wstrb_r[0] : s_axi_wstrb[0]);
    assign raddr = s_axi_araddr[9:2];
    function mapped;
        input [7:0] a;
        begin
            case (a)
                `VFIC_IDX_FMT, `VFIC_IDX_TEST_A, `VFIC_IDX_TEST_B,
                `VFIC_IDX_TEST_C, `VFIC_IDX_TEST_D, `VFIC_IDX_GAIN_R,
                `VFIC_IDX_GAIN_G, `VFIC_IDX_GAIN_B, `VFIC_IDX_OFS_R,
                `VFIC_IDX_OFS_G, `VFIC_IDX_OFS_B, `VFIC_IDX_CLAMP,
                `VFIC_IDX_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction
    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `VFIC_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            fmt_r <= `VFIC_RST_FMT;
            test_a_r <= `VFIC_RST_TEST_A;
            test_b_r <= `VFIC_RST_TEST_B;
            gain_r_r <= `VFIC_RST_GAIN;
            gain_g_r <= `VFIC_RST_GAIN;
            gain_b_r <= `VFIC_RST_GAIN;
            ofs_r_r <= `VFIC_RST_OFS;
            ofs_g_r <= `VFIC_RST_OFS;
            ofs_b_r <= `VFIC_RST_OFS;
            clamp_r <= `VFIC_RST_CLAMP;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if ((aw_have_r || (s_axi_awvalid && s_axi_awready)) &&
                (w_have_r || (s_axi_wvalid && s_axi_wready)) &&
                !s_axi_bvalid)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr) ? `VFIC_RESP_OKAY :
                    `VFIC_RESP_SLVERR;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                if (do_write)
                begin
                    case (waddr)
                        `VFIC_IDX_FMT: fmt_r <= wbyte;
                        `VFIC_IDX_TEST_A: test_a_r <= wbyte;
                        `VFIC_IDX_TEST_B: test_b_r <= wbyte;
                        `VFIC_IDX_GAIN_R: gain_r_r <= wbyte;
                        `VFIC_IDX_GAIN_G: gain_g_r <= wbyte;
                        `VFIC_IDX_GAIN_B: gain_b_r <= wbyte;
                        `VFIC_IDX_OFS_R: ofs_r_r <= wbyte[6:0];
                        `VFIC_IDX_OFS_G: ofs_g_r <= wbyte[6:0];
                        `VFIC_IDX_OFS_B: ofs_b_r <= wbyte[6:0];
                        `VFIC_IDX_CLAMP: clamp_r <= wbyte[0];
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `VFIC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(raddr) ? `VFIC_RESP_OKAY :
                `VFIC_RESP_SLVERR;
            case (raddr)
                `VFIC_IDX_FMT: s_axi_rdata <= {24'h000000, fmt_r};
                `VFIC_IDX_TEST_A: s_axi_rdata <= {24'h000000, test_a_r};
                `VFIC_IDX_TEST_B: s_axi_rdata <= {24'h000000, test_b_r};
                `VFIC_IDX_TEST_C: s_axi_rdata <= {24'h000000, test_c_i};
                `VFIC_IDX_TEST_D: s_axi_rdata <= {24'h000000, test_d_i};
                `VFIC_IDX_GAIN_R: s_axi_rdata <= {24'h000000, gain_r_r};
                `VFIC_IDX_GAIN_G: s_axi_rdata <= {24'h000000, gain_g_r};
                `VFIC_IDX_GAIN_B: s_axi_rdata <= {24'h000000, gain_b_r};
                `VFIC_IDX_OFS_R: s_axi_rdata <= {25'h0000000, ofs_r_r};
                `VFIC_IDX_OFS_G: s_axi_rdata <= {25'h0000000, ofs_g_r};
                `VFIC_IDX_OFS_B: s_axi_rdata <= {25'h0000000, ofs_b_r};
                `VFIC_IDX_CLAMP: s_axi_rdata <= {31'h00000000, clamp_r};
                `VFIC_IDX_STATUS: s_axi_rdata <= {24'h000000, fmt_act};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // ----------------------------------------
    // Pixel-synchronous active settings
    // ----------------------------------------
    vfic_sync_upd #(.W(8), .INIT(`VFIC_RST_FMT)) u_fmt (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(fmt_r), .q_o(fmt_act));
    vfic_sync_upd #(.W(8), .INIT(`VFIC_RST_GAIN)) u_gr (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(gain_r_r), .q_o(gr_act));
    vfic_sync_upd #(.W(8), .INIT(`VFIC_RST_GAIN)) u_gg (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(gain_g_r), .q_o(gg_act));
    vfic_sync_upd #(.W(8), .INIT(`VFIC_RST_GAIN)) u_gb (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(gain_b_r), .q_o(gb_act));
    vfic_sync_upd #(.W(7), .INIT(`VFIC_RST_OFS)) u_or (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(ofs_r_r), .q_o(or_act));
    vfic_sync_upd #(.W(7), .INIT(`VFIC_RST_OFS)) u_og (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(ofs_g_r), .q_o(og_act));
    vfic_sync_upd #(.W(7), .INIT(`VFIC_RST_OFS)) u_ob (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(ofs_b_r), .q_o(ob_act));
    vfic_sync_upd #(.W(1), .INIT(`VFIC_RST_CLAMP)) u_cl (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .upd_i(pix_upd_i),
        .d_i(clamp_r), .q_o(cl_act));
    // ----------------------------------------
    // Source select and output formatting
    // ----------------------------------------
    wire sel = fmt_act[`VFIC_FMT_SRC];
    wire [7:0] mr = sel ? port1_r_i : port0_r_i;
    wire [7:0] mg = sel ? port1_g_i : port0_g_i;
    wire [7:0] mb = sel ? port1_b_i : port0_b_i;
    wire dual = fmt_act[`VFIC_FMT_DUAL];
    wire swp = fmt_act[`VFIC_FMT_ODDSWAP];
    wire yuv = fmt_act[`VFIC_FMT_422];
    wire to_b = dual && (phase_r ^ swp);
    // Red output carries V and U on alternate pixels in 4:2:2 mode
    wire [7:0] mrc = (yuv && uv_ph_r) ? mb : mr;
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r_a_o <= 8'h00;
            r_b_o <= 8'h00;
            g_a_o <= 8'h00;
            g_b_o <= 8'h00;
            b_a_o <= 8'h00;
            b_b_o <= 8'h00;
            b_oe_n_o <= 1'b0;
            hs_o <= 1'b0;
            vs_o <= 1'b0;
            phase_r <= 1'b0;
            uv_ph_r <= 1'b0;
            ext_clk_sel_o <= 1'b0;
            bandwidth_o <= 2'h3;
            gain_o <= {3{`VFIC_RST_GAIN}};
            offset_o <= {3{`VFIC_RST_OFS}};
            clamp_mid_rb_o <= 1'b0;
            src_sel_o <= 1'b0;
        end
        else
        begin
            phase_r <= dual ? ~phase_r : 1'b0;
            uv_ph_r <= yuv ? ~uv_ph_r : 1'b0;
            hs_o <= sel ? port1_hs_i : port0_hs_i;
            vs_o <= sel ? port1_vs_i : port0_vs_i;
            if (!to_b)
            begin
                r_a_o <= mrc;
                g_a_o <= mg;
                b_a_o <= mb;
            end
            else
            begin
                r_b_o <= mrc;
                g_b_o <= mg;
                b_b_o <= mb;
            end
            b_oe_n_o <= yuv;
            ext_clk_sel_o <= fmt_act[`VFIC_FMT_EXTCLK];
            bandwidth_o <= fmt_act[`VFIC_FMT_BW_HI:`VFIC_FMT_BW_LO];
            gain_o <= {gr_act, gg_act, gb_act};
            offset_o <= {or_act, og_act, ob_act};
            clamp_mid_rb_o <= cl_act;
            src_sel_o <= sel;
        end
    end
endmodule
`default_nettype wire

// File: testbench/vfic_scaler_model.sv
`timescale 1ns/100ps
`default_nettype none
module vfic_scaler_model (
    input wire logic clk_i,
    input wire logic [7:0] r_i,
    input wire logic [7:0] g_i,
    input wire logic [7:0] b_i,
    input wire logic b_oe_n_i,
    output logic [23:0] pix_o
);
// Released blue line shows no stable level
always @(posedge clk_i)
    pix_o <= {r_i, g_i, b_oe_n_i ? ~pix_o[7:0] : b_i};
endmodule
`default_nettype wire

// File: testbench/vfic_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "vfic_consts.vh"
module vfic_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic pix_upd_i,
    input wire logic port0_hs_i,
    input wire logic port0_vs_i,
    input wire logic port1_hs_i,
    input wire logic port1_vs_i,
    input wire logic hs_o,
    input wire logic vs_o,
    input wire logic ext_clk_sel_o,
    input wire logic [1:0] bandwidth_o,
    input wire logic [23:0] gain_o,
    input wire logic [20:0] offset_o,
    input wire logic clamp_mid_rb_o,
    input wire logic src_sel_o,
    input wire logic b_oe_n_o
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!rst_n_i);
// ----------------------------------------
// Bus answers
// ----------------------------------------
property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid;
endproperty
a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
property p_wr_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
endproperty
a_wr_busy: assert property (p_wr_busy) else $error("write not refused");
property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
endproperty
a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
endproperty
a_rd_busy: assert property (p_rd_busy) else $error("read not refused");
property p_rd_bad;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h100
        |=> s_axi_rresp == `VFIC_RESP_SLVERR && s_axi_rdata == 32'h0;
endproperty
a_rd_bad: assert property (p_rd_bad) else $error("bad unmapped read");
// ----------------------------------------
// Settings and video path
// ----------------------------------------
property p_defaults;
    $rose(rst_n_i) |-> bandwidth_o == 2'h3 && gain_o == 24'h808080
        && offset_o == 21'h102040 && !ext_clk_sel_o && !src_sel_o;
endproperty
a_defaults: assert property (p_defaults) else $error("bad defaults");
property p_settle;
    $changed({bandwidth_o, ext_clk_sel_o, gain_o, offset_o, clamp_mid_rb_o,
        src_sel_o, b_oe_n_o}) |-> $past(pix_upd_i) || $past(pix_upd_i, 2)
        || $past(pix_upd_i, 3);
endproperty
a_settle: assert property (p_settle) else $error("setting moved early");
property p_sync;
    $past(rst_n_i) && $stable(src_sel_o) |-> {hs_o, vs_o} == (src_sel_o
        ? $past({port1_hs_i, port1_vs_i}) : $past({port0_hs_i, port0_vs_i}));
endproperty
a_sync: assert property (p_sync) else $error("wrong sync source");
endmodule
bind vfic_top vfic_chk i_vfic_chk (.*);
`default_nettype wire

// File: testbench/vfic_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vfic_top_tb;
logic clk_i = 1'h0, rst_n_i = 1'h0, pix_upd_i = 1'h0;
logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hF;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
logic s_axi_rvalid, b_oe_n_o, hs_o, vs_o, ext_clk_sel_o;
logic clamp_mid_rb_o, src_sel_o;
logic [1:0] s_axi_bresp, s_axi_rresp, bandwidth_o;
logic [7:0] port0_r_i = 8'h11, port0_g_i = 8'h22, port0_b_i = 8'h33;
logic [7:0] port1_r_i = 8'h44, port1_g_i = 8'h55, port1_b_i = 8'h66;
logic port0_hs_i = 1'h1, port0_vs_i = 1'h0;
logic port1_hs_i = 1'h0, port1_vs_i = 1'h1;
logic [7:0] test_c_i = 8'h5A, test_d_i = 8'hA5;
logic [7:0] r_a_o, r_b_o, g_a_o, g_b_o, b_a_o, b_b_o;
logic [23:0] gain_o, pix_q;
logic [20:0] offset_o;
integer n_errors = 0, n_tests = 0;
always #2.5 clk_i = ~clk_i;
vfic_top i_vfic_top (.*);
vfic_scaler_model i_vfic_scaler_model (.clk_i(clk_i), .r_i(r_a_o),
    .g_i(g_a_o), .b_i(b_a_o), .b_oe_n_i(b_oe_n_o), .pix_o(pix_q));
task summarize;
begin
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
end
endtask
task chk(input [33:0] got, input [33:0] exp);
begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task timeout;
begin
    n_errors = n_errors + 1;
    summarize;
end
endtask
// ----------------------------------------
// Bus cycles and pixel update strobe
// ----------------------------------------
task wr(input [31:0] a, input [31:0] d, input [1:0] er);
    integer k;
    reg ta, tw, tb, done;
    reg [1:0] r;
begin
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    done = 0;
    for (k = 0; k < 64 && !done; k = k + 1)
    begin
        @(negedge clk_i);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid === 1'h1;
        r = s_axi_bresp;
        @(posedge clk_i);
        if (ta) s_axi_awvalid <= 1'h0;
        if (tw) s_axi_wvalid <= 1'h0;
        if (tb) s_axi_bready <= 1'h0;
        done = tb;
    end
    if (!done) timeout;
    else chk(r, er);
end
endtask
task rd(input [31:0] a, input [31:0] ed, input [1:0] er);
    integer k;
    reg ta, done;
    reg [33:0] r;
begin
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    done = 0;
    for (k = 0; k < 64 && !done; k = k + 1)
    begin
        @(negedge clk_i);
        ta = s_axi_arvalid && s_axi_arready;
        done = s_axi_rvalid === 1'h1;
        r = {s_axi_rresp, s_axi_rdata};
        @(posedge clk_i);
        if (ta) s_axi_arvalid <= 1'h0;
        if (done) s_axi_rready <= 1'h0;
    end
    if (!done) timeout;
    else chk(r, {er, ed});
end
endtask
task upd;
begin
    @(posedge clk_i);
    pix_upd_i <= 1'h1;
    @(posedge clk_i);
    pix_upd_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_reset;
begin
    rd(32'h54, 32'hC6, 2'h0);
    rd(32'h58, 32'hFF, 2'h0);
    rd(32'h5C, 32'h00, 2'h0);
    rd(32'h04, 32'h80, 2'h0);
    rd(32'h10, 32'h40, 2'h0);
    chk(gain_o, 24'h808080);
    chk(clamp_mid_rb_o, 1'h0);
end
endtask
task t_modes;
    integer j;
    reg [1:0] pv;
begin
    pv = 2'h3;
    for (j = 0; j < 4; j = j + 1)
    begin
        wr(32'h54, {28'h0, j[1], j[1:0], j[0]}, 2'h0);
        @(negedge clk_i);
        chk(bandwidth_o, pv);
        upd;
        chk(bandwidth_o, j[1:0]);
        chk(ext_clk_sel_o, j[0]);
        chk(src_sel_o, j[1]);
        chk(r_a_o, j[1] ? 8'h44 : 8'h11);
        chk({hs_o, vs_o}, j[1] ? 2'h1 : 2'h2);
        chk(pix_q, j[1] ? 24'h445566 : 24'h112233);
        pv = j[1:0];
    end
end
endtask
task t_fmt;
    reg [7:0] v;
begin
    wr(32'h54, 32'h10, 2'h0);
    upd;
    chk(b_oe_n_o, 1'h1);
    chk(g_a_o, 8'h22);
    v = r_a_o;
    @(negedge clk_i);
    chk(v ^ r_a_o, 8'h22);
    wr(32'h54, 32'h80, 2'h0);
    upd;
    @(posedge clk_i);
    port0_r_i <= 8'h77;
    port0_b_i <= 8'h88;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({r_a_o, r_b_o}, 16'h7777);
    chk({b_b_o, b_oe_n_o}, 9'h110);
    @(posedge clk_i);
    port0_r_i <= 8'h11;
    port0_b_i <= 8'h33;
    wr(32'h54, 32'hA0, 2'h0);
    upd;
    @(posedge clk_i);
    port0_g_i <= 8'h99;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({g_a_o, g_b_o}, 16'h9999);
    @(posedge clk_i);
    port0_g_i <= 8'h22;
end
endtask
task t_gain;
begin
    wr(32'h08, 32'h00, 2'h0);
    wr(32'h18, 32'h7F, 2'h0);
    wr(32'h1C, 32'h01, 2'h0);
    upd;
    chk(gain_o, 24'h800080);
    chk(offset_o, {7'h40, 7'h40, 7'h7F});
    chk(clamp_mid_rb_o, 1'h1);
    rd(32'h18, 32'h7F, 2'h0);
    rd(32'h20, 32'hA0, 2'h0);
end
endtask
task t_test;
begin
    rd(32'h60, 32'h5A, 2'h0);
    rd(32'h64, 32'hA5, 2'h0);
    wr(32'h58, 32'h12, 2'h0);
    rd(32'h58, 32'h12, 2'h0);
    wr(32'h100, 32'h0, 2'h2);
    rd(32'h100, 32'h0, 2'h2);
end
endtask
initial
begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    t_reset;
    t_modes;
    t_fmt;
    t_gain;
    t_test;
    summarize;
end
endmodule
`default_nettype wire
